// File: rtl/e3_rx_overhead_map.vh
`ifndef E3_RX_OVERHEAD_MAP_VH
`define E3_RX_OVERHEAD_MAP_VH

// overhead word carried per frame: 10 alignment bits, alarm bit, national
`define OH_WORD_W        12
`define OH_MSB           11
`define OH_LAST_BIT      4'hB
`define OH_FIRST_BIT     4'h0
`define OH_IDX_W         4
`define OH_WORD_RESET    12'h000

// bit positions of the word, first bit sent is the highest
`define OH_ALIGN_MSB     11
`define OH_ALIGN_LSB     2
`define OH_ALARM_BIT     1
`define OH_NATIONAL_BIT  0

// output clock periods per overhead bit and the strobe slot within it
`define SLOT_W           3
`define SLOT_LAST        3'h7
`define SLOT_FIRST       3'h0
`define SLOT_STROBE      3'h3

// nominal output clock rate in E3 operation, in kHz
`define E3_RATE_KHZ      34368

// two-entry word buffer
`define BUF_DEPTH        2
`define BUF_CNT_W        2
`define BUF_CNT_EMPTY    2'h0
`define BUF_CNT_ONE      2'h1
`define BUF_CNT_FULL     2'h2
`define BUF_PTR_RESET    1'h0

// sequencer states
`define ST_W             1
`define ST_IDLE          1'h0
`define ST_SEND          1'h1

`endif

// File: rtl/oh_word_buffer.v
`timescale 1ns/1ps
`include "e3_rx_overhead_map.vh"

// two-entry buffer of overhead words with valid and ready on both sides
module oh_word_buffer (
  input  wire                  clk,
  input  wire                  rst_b,
  input  wire                  in_valid,
  input  wire [`OH_MSB:0]      in_data,
  output wire                  in_ready,
  output wire                  out_valid,
  output wire [`OH_MSB:0]      out_data,
  input  wire                  out_ready
);

  reg  [`OH_MSB:0]     mem_reg [0:`BUF_DEPTH-1];
  reg                  wr_ptr_reg;
  reg                  rd_ptr_reg;
  reg  [`BUF_CNT_W-1:0] cnt_reg;
  wire                 push;
  wire                 pop;

  // full and empty come straight from the occupancy count
  assign in_ready  = (cnt_reg != `BUF_CNT_FULL);
  assign out_valid = (cnt_reg != `BUF_CNT_EMPTY);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointers and occupancy
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= `BUF_PTR_RESET;
      rd_ptr_reg <= `BUF_PTR_RESET;
      cnt_reg    <= `BUF_CNT_EMPTY;
    end else begin
      if (push)
        wr_ptr_reg <= ~wr_ptr_reg;
      if (pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      if (push & ~pop)
        cnt_reg <= cnt_reg + `BUF_CNT_ONE;
      else if (pop & ~push)
        cnt_reg <= cnt_reg - `BUF_CNT_ONE;
    end
  end

  // storage, written only on an accepted word
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_reg[0] <= `OH_WORD_RESET;
      mem_reg[1] <= `OH_WORD_RESET;
    end else if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

endmodule // oh_word_buffer

// File: rtl/e3_rx_overhead_strobe_port.v
// Operation
// - overhead bits of each frame leave serially on the data output.
// - strobe is high one output clock period near each bit's centre.
// - marker is high for the whole first overhead bit of a frame.
// - output clock is line clock when loop timed, else local clock.
// - in E3 operation the output clock runs at 34.368 MHz.
// - counts 0 to 9 alignment bits 9 down to 0, 10 alarm, 11 national.
// - data output is always active; nothing can disable it.
`timescale 1ns/1ps
`include "e3_rx_overhead_map.vh"

module e3_rx_overhead_strobe_port (
  input  wire               clk,
  input  wire               rst_b,
  input  wire               rx_recovered_line_clock,
  input  wire               tx_local_input_clock,
  input  wire               loop_timing_select,
  input  wire               oh_word_valid,
  input  wire [`OH_MSB:0]   oh_word_data,
  output wire               oh_word_ready,
  output reg                rx_section_out_clock,
  output reg                rx_overhead_data,
  output reg                rx_overhead_strobe,
  output reg                rx_overhead_frame_marker
);

  // synchroniser stages for the pin inputs
  reg                  line_s1_reg;
  reg                  line_s2_reg;
  reg                  local_s1_reg;
  reg                  local_s2_reg;
  reg                  loop_s1_reg;
  reg                  loop_s2_reg;

  // sequencer state
  reg  [`ST_W-1:0]     state_reg;
  reg  [`ST_W-1:0]     state_next;
  reg  [`OH_MSB:0]     shift_reg;
  reg  [`OH_MSB:0]     shift_next;
  reg  [`OH_IDX_W-1:0] bit_idx_reg;
  reg  [`OH_IDX_W-1:0] bit_idx_next;
  reg  [`SLOT_W-1:0]   slot_reg;
  reg  [`SLOT_W-1:0]   slot_next;
  reg                  data_next;
  reg                  strobe_next;
  reg                  marker_next;
  reg                  pop;

  wire                 sel_clk;
  wire                 clk_rise;
  wire                 buf_valid;
  wire [`OH_MSB:0]     buf_data;
  wire                 bit_done;

  // word buffer between the framer core and the serial port
  oh_word_buffer u_buf (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (oh_word_valid),
    .in_data   (oh_word_data),
    .in_ready  (oh_word_ready),
    .out_valid (buf_valid),
    .out_data  (buf_data),
    .out_ready (pop)
  );

  // two flip-flops on each pin before any logic sees it
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      line_s1_reg  <= 1'h0;
      line_s2_reg  <= 1'h0;
      local_s1_reg <= 1'h0;
      local_s2_reg <= 1'h0;
      loop_s1_reg  <= 1'h0;
      loop_s2_reg  <= 1'h0;
    end else begin
      line_s1_reg  <= rx_recovered_line_clock;
      line_s2_reg  <= line_s1_reg;
      local_s1_reg <= tx_local_input_clock;
      local_s2_reg <= local_s1_reg;
      loop_s1_reg  <= loop_timing_select;
      loop_s2_reg  <= loop_s1_reg;
    end
  end

  // timing source select
  // recovered line clock when loop timed, local oscillator otherwise
  assign sel_clk = loop_s2_reg ? line_s2_reg : local_s2_reg;

  // clock passed straight through
  // the output clock copies the selected source, so its rate is the
  // selected source's rate; the previous copy also serves as the edge reference
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      rx_section_out_clock <= 1'h0;
    else
      rx_section_out_clock <= sel_clk;
  end

  // rising edge of the output clock; port outputs change only here so
  // the terminal sees them settled at the following falling edge
  assign clk_rise = sel_clk & ~rx_section_out_clock;

  // last output clock period of the current bit
  assign bit_done = (slot_reg == `SLOT_LAST);

  // sequencer: one word per frame, each bit held for a fixed slot count
  always @* begin
    state_next   = state_reg;
    shift_next   = shift_reg;
    bit_idx_next = bit_idx_reg;
    slot_next    = slot_reg;
    data_next    = rx_overhead_data;
    strobe_next  = rx_overhead_strobe;
    marker_next  = rx_overhead_frame_marker;
    pop          = 1'h0;
    if (clk_rise) begin
      case (state_reg)
        `ST_IDLE: begin
          strobe_next = 1'h0;
          marker_next = 1'h0;
          if (buf_valid) begin
            pop          = 1'h1;
            shift_next   = buf_data;
            data_next    = buf_data[`OH_MSB];
            marker_next  = 1'h1;
            bit_idx_next = `OH_FIRST_BIT;
            slot_next    = `SLOT_FIRST;
            state_next   = `ST_SEND;
          end
        end
        `ST_SEND: begin
          slot_next   = slot_reg + 3'h1;
          strobe_next = (slot_next == `SLOT_STROBE);
          if (bit_done) begin
            slot_next = `SLOT_FIRST;
            if (bit_idx_reg == `OH_LAST_BIT) begin
              // next frame word follows back to back when it is ready
              marker_next = 1'h0;
              if (buf_valid) begin
                pop          = 1'h1;
                shift_next   = buf_data;
                data_next    = buf_data[`OH_MSB];
                marker_next  = 1'h1;
                bit_idx_next = `OH_FIRST_BIT;
              end else begin
                state_next = `ST_IDLE;
              end
            end else begin
              // alignment msb first
              // next bit shifts up to the top, alarm then national last
              shift_next   = {shift_reg[`OH_MSB-1:0], 1'h0};
              data_next    = shift_reg[`OH_MSB-1];
              marker_next  = 1'h0;
              bit_idx_next = bit_idx_reg + 4'h1;
            end
          end
        end
        default: begin
          state_next  = `ST_IDLE;
          strobe_next = 1'h0;
          marker_next = 1'h0;
        end
      endcase
    end
  end

  // no disable path
  // data and marker only move at the start of a bit; the output is never
  // gated off, it keeps the last bit while waiting for the next frame
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg                <= `ST_IDLE;
      shift_reg                <= `OH_WORD_RESET;
      bit_idx_reg              <= `OH_FIRST_BIT;
      slot_reg                 <= `SLOT_FIRST;
      rx_overhead_data         <= 1'h0;
      rx_overhead_strobe       <= 1'h0;
      rx_overhead_frame_marker <= 1'h0;
    end else begin
      state_reg                <= state_next;
      shift_reg                <= shift_next;
      bit_idx_reg              <= bit_idx_next;
      slot_reg                 <= slot_next;
      rx_overhead_data         <= data_next;
      rx_overhead_strobe       <= strobe_next;
      rx_overhead_frame_marker <= marker_next;
    end
  end

endmodule // e3_rx_overhead_strobe_port

// File: test/oh_checker.sv
`timescale 1ns/1ps
module oh_checker (
  input wire clk,
  input wire rst_b,
  input wire rx_recovered_line_clock,
  input wire tx_local_input_clock,
  input wire loop_timing_select,
  input wire rx_section_out_clock,
  input wire rx_overhead_data,
  input wire rx_overhead_strobe,
  input wire rx_overhead_frame_marker
);
  wire      sel_clk;
  reg       stb_d_reg;
  reg [3:0] mk_cnt_reg;
  // clock the design should be following
  assign sel_clk = loop_timing_select ? rx_recovered_line_clock
                                      : tx_local_input_clock;
  // strobes counted while the marker is up
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stb_d_reg  <= 1'h0;
      mk_cnt_reg <= 4'h0;
    end else begin
      stb_d_reg <= rx_overhead_strobe;
      if (!rx_overhead_frame_marker)
        mk_cnt_reg <= 4'h0;
      else if (rx_overhead_strobe && !stb_d_reg)
        mk_cnt_reg <= mk_cnt_reg + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_rise; $rose(rx_section_out_clock); endsequence
  sequence s_stb_was; s_rise ##0 $past(rx_overhead_strobe); endsequence
  property p_stb_edge; $changed(rx_overhead_strobe) |-> s_rise; endproperty
  a_stb_edge: assert property (p_stb_edge)
    else $error("strobe moved off clock rise");
  property p_stb_one; s_stb_was |-> !rx_overhead_strobe; endproperty
  a_stb_one: assert property (p_stb_one)
    else $error("strobe longer than one period");
  property p_dat_edge; $changed(rx_overhead_data) |-> s_rise; endproperty
  a_dat_edge: assert property (p_dat_edge)
    else $error("data moved off clock rise");
  property p_dat_stb; rx_overhead_strobe |-> $stable(rx_overhead_data);
  endproperty
  a_dat_stb: assert property (p_dat_stb)
    else $error("data moved under strobe");
  property p_mk_edge;
    $changed(rx_overhead_frame_marker) |-> s_rise;
  endproperty
  a_mk_edge: assert property (p_mk_edge)
    else $error("marker moved off clock rise");
  property p_mk_one; $fell(rx_overhead_frame_marker) |-> mk_cnt_reg == 4'h1;
  endproperty
  a_mk_one: assert property (p_mk_one)
    else $error("marker did not span one strobe");
  property p_mk_start;
    $rose(rx_overhead_frame_marker) |-> !rx_overhead_strobe;
  endproperty
  a_mk_start: assert property (p_mk_start)
    else $error("marker rose with strobe");
  property p_clk_src;
    $past(rst_b, 3) && $past(loop_timing_select, 3) == loop_timing_select
      |-> rx_section_out_clock == $past(sel_clk, 3);
  endproperty
  a_clk_src: assert property (p_clk_src)
    else $error("output clock not from selected source");
endmodule // oh_checker

bind e3_rx_overhead_strobe_port oh_checker chk (
  .clk, .rst_b, .rx_recovered_line_clock, .tx_local_input_clock,
  .loop_timing_select, .rx_section_out_clock, .rx_overhead_data,
  .rx_overhead_strobe, .rx_overhead_frame_marker
);

// File: test/oh_terminal.sv
`timescale 1ns/1ps
// terminal side: rebuilds each frame's overhead word
module oh_terminal (
  input  wire        rx_section_out_clock,
  input  wire        rx_overhead_data,
  input  wire        rx_overhead_strobe,
  input  wire        rx_overhead_frame_marker,
  output reg  [11:0] got_word,
  output int         got_n
);
  int cnt = 12;
  always @(negedge rx_section_out_clock) begin
    if (rx_overhead_strobe === 1'h1) begin
      if (rx_overhead_frame_marker === 1'h1)
        cnt = 0;
      if (cnt < 12)
        got_word = {got_word[10:0], rx_overhead_data};
      if (cnt == 11)
        got_n++;
      cnt++;
    end
  end
endmodule // oh_terminal

// File: test/e3_rx_overhead_strobe_port_bench.sv
`timescale 1ns/1ps
`define check_eq(got, exp) begin check_count++; if ((got) !== (exp)) begin \
  failures++; $display("ERROR t=%0t %h %h", $time, got, exp); end end
module e3_rx_overhead_strobe_port_bench;
  reg         clk = 1'h0;
  reg         rst_b = 1'h0;
  reg         rx_recovered_line_clock = 1'h0;
  reg         tx_local_input_clock = 1'h0;
  reg         loop_timing_select = 1'h1;
  reg         oh_word_valid = 1'h0;
  reg  [11:0] oh_word_data = 12'h000;
  reg         saw_full = 1'h0;
  wire        oh_word_ready;
  wire        rx_section_out_clock;
  wire        rx_overhead_data;
  wire        rx_overhead_strobe;
  wire        rx_overhead_frame_marker;
  wire [11:0] got_word;
  int         got_n;
  int         failures;
  int         check_count;
  e3_rx_overhead_strobe_port uut (
    .clk, .rst_b, .rx_recovered_line_clock, .tx_local_input_clock,
    .loop_timing_select, .oh_word_valid, .oh_word_data, .oh_word_ready,
    .rx_section_out_clock, .rx_overhead_data, .rx_overhead_strobe,
    .rx_overhead_frame_marker);
  oh_terminal term (.rx_section_out_clock, .rx_overhead_data,
    .rx_overhead_strobe, .rx_overhead_frame_marker, .got_word, .got_n);
  // system clock, then link clocks that run only while selected
  always #2 clk = ~clk;
  initial #0.7 forever #16 if (loop_timing_select)
    rx_recovered_line_clock = ~rx_recovered_line_clock;
  initial #1.3 forever #16 if (!loop_timing_select)
    tx_local_input_clock = ~tx_local_input_clock;
  // offer one word and hold it until taken
  task push(input [11:0] w);
    int n;
    begin
      n = 0;
      @(negedge clk);
      oh_word_valid = 1'h1;
      oh_word_data = w;
      @(posedge clk);
      while (oh_word_ready !== 1'h1 && n < 2000) begin
        saw_full = 1'h1;
        n++;
        @(posedge clk);
      end
    end
  endtask
  // wait for the next whole frame at the terminal
  task expect_frame(input [11:0] w);
    int n0;
    int k;
    begin
      n0 = got_n;
      for (k = 0; k < 4000 && got_n == n0; k++)
        @(posedge clk);
      // a frame that never arrives counts as a mismatch
      `check_eq(got_n != n0, 1'h1)
      `check_eq(got_word, w)
    end
  endtask
  // four frames back to back: buffer fills, refuses, drains
  task loop_timed_burst;
    fork
      begin
        push(12'hF41);
        push(12'h0A2);
        push(12'h5C3);
        push(12'h9B0);
        @(negedge clk) oh_word_valid = 1'h0;
      end
      begin
        expect_frame(12'hF41);
        expect_frame(12'h0A2);
        expect_frame(12'h5C3);
        expect_frame(12'h9B0);
        `check_eq(saw_full, 1'h1)
      end
    join
  endtask
  // local timing with the line clock stopped
  task local_timed;
    time t0;
    begin
      // let the last frame finish so the source switches while idle
      repeat (64) @(posedge clk);
      @(negedge clk) loop_timing_select = 1'h0;
      repeat (16) @(posedge clk);
      @(posedge rx_section_out_clock) t0 = $time;
      @(posedge rx_section_out_clock);
      `check_eq($time - t0, 64'h20)
      fork
        push(12'h3E7);
        expect_frame(12'h3E7);
      join
      @(negedge clk) oh_word_valid = 1'h0;
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // reset, scenarios, verdict
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk) rst_b = 1'h1;
    loop_timed_burst;
    local_timed;
    report_and_stop;
  end
  // watchdog
  initial begin
    #60000;
    failures++;
    report_and_stop;
  end
endmodule // e3_rx_overhead_strobe_port_bench
